// ==== verilog/port_pins_with_ext_interrupts.sv ====
`timescale 1ns/1ps

// Summary of operation
// - port0 direction is set once for pins 0-3 and once for pins 4-7.
// - port0 pull-ups switch on or off per group of four pins.
// - ports 1, 2, 3 and 7 take a direction bit for every pin.
// - ports 1, 2, 3 and 7 take a pull-up enable bit for every pin.
// - a pin read returns the synchronised pin level even when driving.
// - inputs a and b allow rise, fall, high and low; inputs c to port3 allow rise, fall and both edges.
// - pins of inputs a, b, c, port2 and port3 also wake from hold and feed timer capture and event lines.
// - port0 pins raise a port interrupt and also wake from hold.
// - the filtered input passes a noise filter before edge detection and also feeds the timer0 event line.
// - port7 pin0 also pulls low for the watchdog output.
// - ports 0-3 choose push-pull or open-drain per pin; port0 loses pull-up when open-drain; port7 pin0 is open-drain, pins 1-3 push-pull.
// - port0 pull-up enable and low or high impedance are chosen per nibble.
// - the reset pin takes an external reset and drives out the internal reset.
// - hold is released by a configured trigger on inputs a, b, c, port2, port3 or by a port0 interrupt source.
module port_pins_with_ext_interrupts (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [23:0] pinIn,
	output logic      [23:0] pinOut,
	output logic      [23:0] pinOeN,
	output logic      [23:0] pullEn,
	output logic      [1:0]  port0LowZ,
	input  wire logic        resetPinIn,
	output logic             resetPinOut,
	output logic             resetPinOeN,
	input  wire logic        internalReset,
	output logic             extResetReq,
	input  wire logic        watchdogOut,
	output logic             irq,
	output logic             holdActive,
	output logic             holdWake,
	output logic             timer0LowCapture,
	output logic             timer0HighCapture,
	output logic             timer0Event,
	output logic             timer1Event
);

	typedef struct packed {
		logic [23:0] s1;
		logic [23:0] s2;
		logic [23:0] prev;
		logic        resS1;
		logic        resS2;
		logic        filt;
		logic        filtPrev;
		logic [7:0]  filtCnt;
		logic [5:0]  p0ctl;
		logic [23:0] data;
		logic [15:0] dir;
		logic [15:0] pull;
		logic [19:0] od;
		logic [19:0] irqcfg;
		logic [6:0]  status;
		logic [6:0]  mask;
		logic [7:0]  p0ien;
		logic        hold;
		logic        wrPend;
		logic [7:0]  wrAddr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic [23:0] pinOut;
		logic [23:0] pinOeN;
		logic [23:0] pullEn;
		logic [1:0]  lowZ;
		logic        resetOeN;
		logic        extReset;
		logic        irq;
		logic        holdWake;
		logic        t0L;
		logic        t0H;
		logic        t0E;
		logic        t1E;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// trigger test; modes an input cannot take never fire
	function automatic logic trigHit(input logic [2:0] mode, input logic cur, input logic prv,
		input logic allowBoth, input logic allowLvl);
		logic hit;
		hit = 1'b0;
		case (mode)
			gpio_pkg::TRIG_RISE: hit = cur & ~prv;
			gpio_pkg::TRIG_FALL: hit = ~cur & prv;
			gpio_pkg::TRIG_BOTH: hit = allowBoth & (cur ^ prv);
			gpio_pkg::TRIG_HIGH: hit = allowLvl & cur;
			gpio_pkg::TRIG_LOW:  hit = allowLvl & ~cur;
			default:             hit = 1'b0;
		endcase
		return hit;
	endfunction

	// full port direction vector: port0 nibbles expand, others per pin
	function automatic logic [23:0] dirVec(input logic [5:0] ctl, input logic [15:0] d);
		return {d, {4{ctl[gpio_pkg::CTL_DIR_HI]}}, {4{ctl[gpio_pkg::CTL_DIR_LO]}}};
	endfunction

	// register read mux; unmapped words read zero
	function automatic logic [31:0] regRead(input state_t s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			gpio_pkg::ADDR_P0CTL:  v = {26'h0, s.p0ctl};
			gpio_pkg::ADDR_DATA:   v = {8'h00, s.data};
			gpio_pkg::ADDR_DIR:    v = {16'h0000, s.dir};
			gpio_pkg::ADDR_PULL:   v = {16'h0000, s.pull};
			gpio_pkg::ADDR_OD:     v = {12'h000, s.od};
			gpio_pkg::ADDR_PINS:   v = {8'h00, s.s2};
			gpio_pkg::ADDR_IRQCFG: v = {12'h000, s.irqcfg};
			gpio_pkg::ADDR_STATUS: v = {25'h0, s.status};
			gpio_pkg::ADDR_MASK:   v = {25'h0, s.mask};
			gpio_pkg::ADDR_HOLD:   v = {31'h0, s.hold};
			gpio_pkg::ADDR_P0IEN:  v = {24'h0, s.p0ien};
			default:               v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	logic [6:0]  evt;
	logic [23:0] dirAll;
	logic [7:0]  filtLen;
	logic [6:0]  stClr;
	logic        wake;

	// all next-state logic of the block
	always_comb begin
		state_nxt = state_r;
		evt       = 7'h00;
		stClr     = 7'h00;

		// two-flop synchronisers; only s2 and later are looked at
		state_nxt.s1    = pinIn;
		state_nxt.s2    = state_r.s1;
		state_nxt.prev  = state_r.s2;
		state_nxt.resS1 = resetPinIn;
		state_nxt.resS2 = state_r.resS1;

		// filter, level must hold the selected time before it is taken
		case (state_r.irqcfg[gpio_pkg::FSEL_LO +: 2])
			2'h1:    filtLen = gpio_pkg::FILT_CYC1;
			2'h2:    filtLen = gpio_pkg::FILT_CYC2;
			default: filtLen = gpio_pkg::FILT_CYC0;
		endcase
		state_nxt.filtPrev = state_r.filt;
		if (state_r.s2[gpio_pkg::P7_LO + 3] == state_r.filt) begin
			state_nxt.filtCnt = 8'h00;
		end else if (state_r.filtCnt + 8'h01 >= filtLen) begin
			state_nxt.filt    = state_r.s2[gpio_pkg::P7_LO + 3];
			state_nxt.filtCnt = 8'h00;
		end else begin
			state_nxt.filtCnt = state_r.filtCnt + 8'h01;
		end

		// level modes only on a and b, both-edge only on the rest
		evt[gpio_pkg::IRQ_A] = trigHit(state_r.irqcfg[0 +: 3], state_r.s2[gpio_pkg::P7_LO],
			state_r.prev[gpio_pkg::P7_LO], 1'b0, 1'b1);
		evt[gpio_pkg::IRQ_B] = trigHit(state_r.irqcfg[3 +: 3], state_r.s2[gpio_pkg::P7_LO + 1],
			state_r.prev[gpio_pkg::P7_LO + 1], 1'b0, 1'b1);
		evt[gpio_pkg::IRQ_C] = trigHit(state_r.irqcfg[6 +: 3], state_r.s2[gpio_pkg::P7_LO + 2],
			state_r.prev[gpio_pkg::P7_LO + 2], 1'b1, 1'b0);
		evt[gpio_pkg::IRQ_F] = trigHit(state_r.irqcfg[9 +: 3], state_r.filt, state_r.filtPrev, 1'b1, 1'b0);
		// port2 and port3 inputs each serve two pins
		evt[gpio_pkg::IRQ_P2] = trigHit(state_r.irqcfg[12 +: 3], state_r.s2[gpio_pkg::P2_LO],
			state_r.prev[gpio_pkg::P2_LO], 1'b1, 1'b0) | trigHit(state_r.irqcfg[12 +: 3],
			state_r.s2[gpio_pkg::P2_LO + 1], state_r.prev[gpio_pkg::P2_LO + 1], 1'b1, 1'b0);
		evt[gpio_pkg::IRQ_P3] = trigHit(state_r.irqcfg[15 +: 3], state_r.s2[gpio_pkg::P3_LO],
			state_r.prev[gpio_pkg::P3_LO], 1'b1, 1'b0) | trigHit(state_r.irqcfg[15 +: 3],
			state_r.s2[gpio_pkg::P3_LO + 1], state_r.prev[gpio_pkg::P3_LO + 1], 1'b1, 1'b0);
		// falling edge on an enabled port0 pin is a source
		evt[gpio_pkg::ST_PORT0] = |(state_r.p0ien & ~state_r.s2[7:0] & state_r.prev[7:0]);

		// bus data phase: writes land one cycle after their address phase
		if (state_r.wrPend) begin
			case (state_r.wrAddr)
				gpio_pkg::ADDR_P0CTL:  state_nxt.p0ctl  = hwdata[5:0];
				gpio_pkg::ADDR_DATA:   state_nxt.data   = hwdata[23:0];
				gpio_pkg::ADDR_DIR:    state_nxt.dir    = hwdata[15:0];
				gpio_pkg::ADDR_PULL:   state_nxt.pull   = hwdata[15:0];
				gpio_pkg::ADDR_OD:     state_nxt.od     = hwdata[19:0];
				gpio_pkg::ADDR_IRQCFG: state_nxt.irqcfg = hwdata[19:0];
				gpio_pkg::ADDR_STATUS: stClr            = hwdata[6:0];
				gpio_pkg::ADDR_MASK:   state_nxt.mask   = hwdata[6:0];
				gpio_pkg::ADDR_HOLD:   state_nxt.hold   = hwdata[0];
				gpio_pkg::ADDR_P0IEN:  state_nxt.p0ien  = hwdata[7:0];
				default:               state_nxt.hold   = state_r.hold;
			endcase
		end

		// sticky status, write one to clear, a new event beats the clear
		state_nxt.status = (state_r.status & ~stClr) | evt;
		state_nxt.irq    = |(state_nxt.status & state_nxt.mask);

		// wake on a, b, c, port2 triggers or port0 source
		// port3 input is a wake pin as well
		wake = evt[gpio_pkg::IRQ_A] | evt[gpio_pkg::IRQ_B] | evt[gpio_pkg::IRQ_C] |
			evt[gpio_pkg::IRQ_P2] | evt[gpio_pkg::IRQ_P3] | evt[gpio_pkg::ST_PORT0];
		state_nxt.holdWake = state_r.hold & wake;
		if (state_r.hold & wake) begin
			state_nxt.hold = 1'b0;
		end

		// address phase: read data registered now so it stands in the data phase
		state_nxt.wrPend    = 1'b0;
		state_nxt.hreadyout = 1'b1;
		if (hsel && htrans[1] && hready) begin
			state_nxt.wrPend = hwrite;
			state_nxt.wrAddr = {haddr[7:2], 2'b00};
			if (!hwrite) begin
				state_nxt.hrdata = regRead(state_r, {haddr[7:2], 2'b00});
			end
		end

		// pin drivers; open-drain pins only ever pull low
		dirAll = dirVec(state_nxt.p0ctl, state_nxt.dir);
		for (int i = 0; i < gpio_pkg::P7_LO; i++) begin
			if (state_nxt.od[i]) begin
				state_nxt.pinOut[i] = 1'b0;
				state_nxt.pinOeN[i] = ~(dirAll[i] & ~state_nxt.data[i]);
			end else begin
				state_nxt.pinOut[i] = state_nxt.data[i];
				state_nxt.pinOeN[i] = ~dirAll[i];
			end
		end
		// port7 pin0 fixed open-drain, pins 1-3 push-pull
		// watchdog pulls the shared pin low
		state_nxt.pinOut[gpio_pkg::P7_LO] = 1'b0;
		state_nxt.pinOeN[gpio_pkg::P7_LO] = ~((dirAll[gpio_pkg::P7_LO] & ~state_nxt.data[gpio_pkg::P7_LO])
			| watchdogOut);
		state_nxt.pinOut[23:21] = state_nxt.data[23:21];
		state_nxt.pinOeN[23:21] = ~dirAll[23:21];

		// nibble pull-up, dropped on open-drain port0 pins
		// separate enable and impedance per nibble
		state_nxt.pullEn[3:0] = {4{state_nxt.p0ctl[gpio_pkg::CTL_PU_LO]}} & ~state_nxt.od[3:0];
		state_nxt.pullEn[7:4] = {4{state_nxt.p0ctl[gpio_pkg::CTL_PU_HI]}} & ~state_nxt.od[7:4];
		state_nxt.lowZ = {state_nxt.p0ctl[gpio_pkg::CTL_LOWZ_HI], state_nxt.p0ctl[gpio_pkg::CTL_LOWZ_LO]};
		state_nxt.pullEn[23:8] = state_nxt.pull;

		state_nxt.resetOeN = ~internalReset;
		state_nxt.extReset = ~state_r.resS2;

		// capture and event lines follow the shared pins
		state_nxt.t0L = state_r.s2[gpio_pkg::P7_LO] | state_r.s2[gpio_pkg::P7_LO + 2];
		state_nxt.t0H = state_r.s2[gpio_pkg::P7_LO + 1] | state_r.filt;
		// filtered pin also counts timer0 events
		state_nxt.t0E = state_r.s2[gpio_pkg::P7_LO + 2] | state_r.filt;
		state_nxt.t1E = |state_r.s2[gpio_pkg::P3_LO + 1:gpio_pkg::P2_LO];
	end

	// one register for the whole state; pins float and the bus is ready in reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= '{pinOeN: 24'hFF_FFFF, resetOeN: 1'b1, hreadyout: 1'b1, resS1: 1'b1, resS2: 1'b1,
				default: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state register, except the constant hresp and resetPinOut
	assign hreadyout         = state_r.hreadyout;
	assign hresp             = 1'b0;
	assign hrdata            = state_r.hrdata;
	assign pinOut            = state_r.pinOut;
	assign pinOeN            = state_r.pinOeN;
	assign pullEn            = state_r.pullEn;
	assign port0LowZ         = state_r.lowZ;
	assign resetPinOut       = 1'b0; // open-drain style, only ever pulls low
	assign resetPinOeN       = state_r.resetOeN;
	assign extResetReq       = state_r.extReset;
	assign irq               = state_r.irq;
	assign holdActive        = state_r.hold;
	assign holdWake          = state_r.holdWake;
	assign timer0LowCapture  = state_r.t0L;
	assign timer0HighCapture = state_r.t0H;
	assign timer0Event       = state_r.t0E;
	assign timer1Event       = state_r.t1E;

endmodule // port_pins_with_ext_interrupts

// ==== shared/gpio_pkg.sv ====
package gpio_pkg;

	// register byte addresses on the bus
	localparam logic [7:0] ADDR_P0CTL  = 8'h00;
	localparam logic [7:0] ADDR_DATA   = 8'h04;
	localparam logic [7:0] ADDR_DIR    = 8'h08;
	localparam logic [7:0] ADDR_PULL   = 8'h0C;
	localparam logic [7:0] ADDR_OD     = 8'h10;
	localparam logic [7:0] ADDR_PINS   = 8'h14;
	localparam logic [7:0] ADDR_IRQCFG = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_MASK   = 8'h20;
	localparam logic [7:0] ADDR_HOLD   = 8'h24;
	localparam logic [7:0] ADDR_P0IEN  = 8'h28;

	// pin vector layout: port0, port1, port2, port3, port7
	localparam int NPINS  = 24;
	localparam int P0_LO  = 0;
	localparam int P1_LO  = 8;
	localparam int P2_LO  = 16;
	localparam int P3_LO  = 18;
	localparam int P7_LO  = 20;

	// port0 control register fields
	localparam int CTL_DIR_LO  = 0;
	localparam int CTL_DIR_HI  = 1;
	localparam int CTL_PU_LO   = 2;
	localparam int CTL_PU_HI   = 3;
	localparam int CTL_LOWZ_LO = 4;
	localparam int CTL_LOWZ_HI = 5;

	// interrupt configuration: 3-bit mode per input, filter select at the top
	localparam int MODE_W     = 3;
	localparam int FSEL_LO    = 18;
	localparam int NSTAT      = 7;
	localparam int ST_PORT0   = 6;

	// status bit order
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;
	localparam int IRQ_C = 2;
	localparam int IRQ_F = 3;
	localparam int IRQ_P2 = 4;
	localparam int IRQ_P3 = 5;

	typedef enum logic [2:0] {
		TRIG_OFF  = 3'b000,
		TRIG_RISE = 3'b001,
		TRIG_FALL = 3'b010,
		TRIG_BOTH = 3'b011,
		TRIG_HIGH = 3'b100,
		TRIG_LOW  = 3'b101
	} trig_t;

	// noise filter time constants in system clock cycles
	localparam logic [7:0] FILT_CYC0 = 8'h01;
	localparam logic [7:0] FILT_CYC1 = 8'h20;
	localparam logic [7:0] FILT_CYC2 = 8'h80;

endpackage

// ==== dv/port_pins_properties.sv ====
`timescale 1ns/1ps

// pin-side relations of the port block, seen from its ports only
module port_pins_properties (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [23:0] pinIn,
	input wire logic [23:0] pinOut,
	input wire logic [23:0] pinOeN,
	input wire logic        resetPinIn,
	input wire logic        resetPinOeN,
	input wire logic        internalReset,
	input wire logic        extResetReq,
	input wire logic        watchdogOut,
	input wire logic        holdActive,
	input wire logic        holdWake,
	input wire logic        timer1Event
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// five samples cover the two-flop synchroniser plus the output flop
	sequence s_pinLow;
		!resetPinIn [*5];
	endsequence
	sequence s_pinHigh;
		resetPinIn [*5];
	endsequence

	property p_extReq; s_pinLow |-> extResetReq; endproperty
	a_extReq: assert property (p_extReq) else $error("reset request missing");
	property p_extIdle; s_pinHigh |-> !extResetReq; endproperty
	a_extIdle: assert property (p_extIdle) else $error("reset request without pin");
	property p_rstDrive; resetPinOeN == !$past(internalReset); endproperty
	a_rstDrive: assert property (p_rstDrive) else $error("reset pin drive wrong");
	property p_p70Od; !pinOut[20]; endproperty
	a_p70Od: assert property (p_p70Od) else $error("port7 pin0 driven high");
	property p_wdt; watchdogOut [*2] |-> !pinOeN[20] && !pinOut[20]; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not on port7 pin0");
	property p_wakePulse; holdWake |=> !holdWake; endproperty
	a_wakePulse: assert property (p_wakePulse) else $error("wake pulse too long");
	property p_wakeFromHold; holdWake |-> $past(holdActive); endproperty
	a_wakeFromHold: assert property (p_wakeFromHold) else $error("wake outside hold");
	property p_t1ev; (|pinIn[19:16]) [*5] |-> timer1Event; endproperty
	a_t1ev: assert property (p_t1ev) else $error("timer1 event missing");
endmodule // port_pins_properties

bind port_pins_with_ext_interrupts port_pins_properties u_props (.clk_sys, .rstn, .pinIn, .pinOut, .pinOeN,
	.resetPinIn, .resetPinOeN, .internalReset, .extResetReq, .watchdogOut, .holdActive, .holdWake, .timer1Event);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
	logic        clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp, irq, holdActive, holdWake;
	logic        resetPinIn, resetPinOut, resetPinOeN, internalReset, extResetReq, watchdogOut;
	logic        timer0LowCapture, timer0HighCapture, timer0Event, timer1Event;
	logic [1:0]  htrans, port0LowZ;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	logic [23:0] pinIn, pinOut, pinOeN, pullEn;
	int          nFail = 0;
	int          checked = 0;

	// zero-wait slave: its own ready closes the loop
	assign hready = hreadyout;

	port_pins_with_ext_interrupts dut (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .pinIn, .pinOut, .pinOeN, .pullEn, .port0LowZ, .resetPinIn,
		.resetPinOut, .resetPinOeN, .internalReset, .extResetReq, .watchdogOut, .irq, .holdActive, .holdWake,
		.timer0LowCapture, .timer0HighCapture, .timer0Event, .timer1Event);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	// one single word transfer; waits on ready, never on a cycle count
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rdata = hrdata;
		hsel <= 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic setPin(int p, logic v);
		@(posedge clk_sys);
		pinIn[p] <= v;
	endtask

	// arm one trigger, put the device in hold, move the pin, then judge
	task automatic trig(int sh, int p, int sb, logic [2:0] md, logic v0, logic exp);
		bus(1'b1, gpio_pkg::ADDR_IRQCFG, 32'(md) << sh);
		setPin(p, v0);
		repeat (6) @(negedge clk_sys);
		bus(1'b1, gpio_pkg::ADDR_STATUS, 32'h7F);
		bus(1'b1, gpio_pkg::ADDR_HOLD, 32'h1);
		setPin(p, !v0);
		repeat (10) @(negedge clk_sys);
		chk("irq", irq, exp);
		chk("hold", holdActive, !(exp && sb != 3));
		bus(1'b0, gpio_pkg::ADDR_STATUS, 32'h0);
		chk("status", rdata, 32'(exp) << sb);
	endtask

	task automatic testPorts();
		bus(1'b0, 8'h2C, 32'h0);
		chk("unmapped", rdata, 32'h0);
		chk("okay", hresp, 1'b0);
		chk("oen rst", pinOeN, 24'hFFFFFF);
		bus(1'b1, gpio_pkg::ADDR_P0CTL, 32'h1);
		chk("p0 oen", pinOeN[7:0], 8'hF0);
		bus(1'b1, gpio_pkg::ADDR_DIR, 32'hFFFF);
		bus(1'b1, gpio_pkg::ADDR_P0CTL, 32'h3);
		bus(1'b1, gpio_pkg::ADDR_DATA, 32'hFFFFFF);
		chk("oen", pinOeN, 24'h100000);
		bus(1'b1, gpio_pkg::ADDR_OD, 32'h1);
		chk("od out", pinOut, 24'hEFFFFE);
		chk("od oen", pinOeN, 24'h100001);
		bus(1'b1, gpio_pkg::ADDR_DIR, 32'h5);
		chk("bit dir", pinOeN[23:8], 16'hFFFA);
		@(posedge clk_sys);
		pinIn <= 24'h5A3C96;
		repeat (4) @(negedge clk_sys);
		bus(1'b0, gpio_pkg::ADDR_PINS, 32'h0);
		chk("pins", rdata, 32'h5A3C96);
		@(posedge clk_sys);
		pinIn <= 24'h0;
		bus(1'b1, gpio_pkg::ADDR_PULL, 32'h1001);
		bus(1'b1, gpio_pkg::ADDR_P0CTL, 32'h1C);
		chk("pull", pullEn, 24'h1001FE);
		chk("lowz", port0LowZ, 2'h1);
		bus(1'b1, gpio_pkg::ADDR_OD, 32'h0);
		bus(1'b1, gpio_pkg::ADDR_P0CTL, 32'h28);
		chk("pull hi", pullEn, 24'h1001F0);
		chk("lowz hi", port0LowZ, 2'h2);
		$display("ports test done");
	endtask

	task automatic testIrq();
		bus(1'b1, gpio_pkg::ADDR_MASK, 32'h7F);
		trig(0, 20, 0, 3'h1, 1'b0, 1'b1);
		trig(0, 20, 0, 3'h2, 1'b1, 1'b1);
		trig(0, 20, 0, 3'h3, 1'b0, 1'b0);
		trig(0, 20, 0, 3'h4, 1'b0, 1'b1);
		trig(3, 21, 1, 3'h5, 1'b1, 1'b1);
		trig(3, 21, 1, 3'h1, 1'b1, 1'b0);
		trig(6, 22, 2, 3'h3, 1'b1, 1'b1);
		trig(6, 22, 2, 3'h4, 1'b0, 1'b0);
		trig(9, 23, 3, 3'h1, 1'b0, 1'b1);
		trig(12, 17, 4, 3'h3, 1'b0, 1'b1);
		trig(15, 18, 5, 3'h2, 1'b1, 1'b1);
		trig(15, 19, 5, 3'h5, 1'b1, 1'b0);
		bus(1'b1, gpio_pkg::ADDR_P0IEN, 32'h1);
		trig(0, 1, 6, 3'h0, 1'b1, 1'b0);
		trig(0, 0, 6, 3'h0, 1'b1, 1'b1);
		bus(1'b1, gpio_pkg::ADDR_MASK, 32'h0);
		chk("irq masked", irq, 1'b0);
		bus(1'b1, gpio_pkg::ADDR_MASK, 32'h40);
		chk("irq unmasked", irq, 1'b1);
		bus(1'b1, gpio_pkg::ADDR_STATUS, 32'h40);
		chk("irq cleared", irq, 1'b0);
		$display("interrupt test done");
	endtask

	// timer lines follow the shared pins; slow filter settings hold back a new level on the filtered input
	task automatic testTimers();
		@(posedge clk_sys);
		pinIn <= 24'h0;
		repeat (6) @(negedge clk_sys);
		chk("t0 low idle", timer0LowCapture, 1'b0);
		chk("t0 high idle", timer0HighCapture, 1'b0);
		chk("t1 event idle", timer1Event, 1'b0);
		@(posedge clk_sys);
		pinIn[22] <= 1'b1;
		pinIn[19] <= 1'b1;
		repeat (6) @(negedge clk_sys);
		chk("t0 low", timer0LowCapture, 1'b1);
		chk("t0 event", timer0Event, 1'b1);
		chk("t0 high off", timer0HighCapture, 1'b0);
		chk("t1 event", timer1Event, 1'b1);
		@(posedge clk_sys);
		pinIn <= 24'h0;
		// 32-cycle filter, rising edge on the filtered input
		bus(1'b1, gpio_pkg::ADDR_IRQCFG, 32'h0004_0200);
		bus(1'b1, gpio_pkg::ADDR_STATUS, 32'h7F);
		setPin(23, 1'b1);
		repeat (20) @(negedge clk_sys);
		bus(1'b0, gpio_pkg::ADDR_STATUS, 32'h0);
		chk("filt 32 early", rdata, 32'h0);
		repeat (20) @(negedge clk_sys);
		bus(1'b0, gpio_pkg::ADDR_STATUS, 32'h0);
		chk("filt 32 taken", rdata, 32'h8);
		chk("t0 high filt", timer0HighCapture, 1'b1);
		// 128-cycle filter, both edges on the filtered input
		bus(1'b1, gpio_pkg::ADDR_IRQCFG, 32'h0008_0600);
		bus(1'b1, gpio_pkg::ADDR_STATUS, 32'h7F);
		setPin(23, 1'b0);
		repeat (100) @(negedge clk_sys);
		bus(1'b0, gpio_pkg::ADDR_STATUS, 32'h0);
		chk("filt 128 early", rdata, 32'h0);
		repeat (40) @(negedge clk_sys);
		bus(1'b0, gpio_pkg::ADDR_STATUS, 32'h0);
		chk("filt 128 taken", rdata, 32'h8);
		$display("timer and filter test done");
	endtask

	task automatic testReset();
		@(posedge clk_sys);
		resetPinIn <= 1'b0;
		watchdogOut <= 1'b1;
		repeat (5) @(negedge clk_sys);
		chk("ext req", extResetReq, 1'b1);
		chk("wdt oen", pinOeN[20], 1'b0);
		@(posedge clk_sys);
		resetPinIn <= 1'b1;
		watchdogOut <= 1'b0;
		internalReset <= 1'b1;
		repeat (5) @(negedge clk_sys);
		chk("ext idle", extResetReq, 1'b0);
		chk("rst drive", resetPinOeN, 1'b0);
		chk("rst out", resetPinOut, 1'b0);
		@(posedge clk_sys);
		internalReset <= 1'b0;
		$display("reset pin test done");
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pinIn = 24'h0;
		resetPinIn = 1'b1;
		internalReset = 1'b0;
		watchdogOut = 1'b0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		testPorts();
		testIrq();
		testTimers();
		testReset();
		end_sim();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		nFail++;
		end_sim();
	end
endmodule // tb_top
